// [uvdc_pkg.sv]
// package for the undervoltage detect control block
// assumes an 8-bit register port at the documented byte addresses
package uvdc_pkg;
  localparam logic [15:0] ADDR_CTRL       = 16'hffbe;
  localparam logic [15:0] ADDR_LEVEL      = 16'hffbf;
  localparam logic [7:0]  CTRL_RESET      = 8'h00;
  localparam logic [7:0]  LEVEL_RESET     = 8'h00;
  localparam logic [7:0]  CAUSE_RESET     = 8'h00;
  localparam int          BIT_ON          = 7;
  localparam int          BIT_REF         = 4;
  localparam int          BIT_ACT         = 1;
  localparam int          BIT_FLAG        = 0;
  localparam int          CAUSE_UV        = 0;
  localparam int          CAUSE_CLKMON    = 1;
  localparam int          CAUSE_WDOG      = 4;
  localparam logic [2:0]  LEVEL_BAD       = 3'h7;
  localparam int          SYNC_STAGES     = 2;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } uvdc_bus_t;

  typedef struct packed {
    logic       on;
    logic       ref_en;
    logic       act_rst;
    logic [2:0] level;
    logic [7:0] cause;
    logic [7:0] rdata;
    logic       irq;
    logic       uv_rst;
    logic       power_on_clear;
  } uvdc_state_t;
endpackage

// [uvdc_sync.sv]
// two-stage synchroniser for an asynchronous level
// assumes mclk runs in every mode, including clock-stopped cpu mode
`timescale 1ns/1ps
module uvdc_sync #(
  parameter int STAGES = 2
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic arst_n,
  // level
  input  wire logic d,
  output logic      q
);
  logic [STAGES-1:0] sh_r;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sh_r <= '0;
    end else begin
      sh_r <= {sh_r[STAGES-2:0], d};
    end
  end

  assign q = sh_r[STAGES-1];
endmodule // uvdc_sync

// [uvdc_ctrl.sv]
// undervoltage detector control, flag and reset-cause bookkeeping
// assumes byte register port, analog comparator and reference outside,
// and that internal reset inputs are one-cycle pulses in mclk domain
`timescale 1ns/1ps
// Function
// - external reset clears the control register to zero
// - bit 7 enables the comparator and detection
// - bit 4 switches the reference generator on or off
// - bit 1 picks interrupt (0) or internal reset (1) on undervoltage
// - bit 0 read-only flag, 1 while below level, 0 when disabled
// - flag drives interrupt only while detector on and interrupt action selected
// - any reset but undervoltage reset clears control bits 7, 4, 1
// - with power-on-clear fitted, reference enable writes are ignored, reference always on
// - undervoltage reset sets reset cause bit 0
// - power-on-clear reset clears the whole reset cause register
// - watchdog, undervoltage, clock-monitor resets only set their own cause bit
// - power-on-clear asserts reset at power-up and while supply below its level
// - detection keeps working in clock-stopped low-power mode
// - control bits 6, 5, 3, 2 read zero
// - level register bits 2:0 pick a level, code 7 prohibited, upper bits zero
module uvdc_ctrl #(
  parameter bit POC_FITTED = 1'b1
) (
  // clock and external reset
  input  wire logic             mclk,
  input  wire logic             arst_n,
  // register port
  input  wire uvdc_pkg::uvdc_bus_t bus,
  output logic [7:0]            rdata,
  // analog side
  input  wire logic             cmp_below,
  input  wire logic             poc_below,
  output logic                  cmp_enable,
  output logic                  ref_enable,
  output logic [2:0]            detect_level_select,
  // reset sources in
  input  wire logic             wdog_rst,
  input  wire logic             clkmon_rst,
  // outputs
  output logic                  undervoltage_irq,
  output logic                  undervoltage_rst,
  output logic                  poc_rst,
  output logic [7:0]            reset_cause_flags
);
  uvdc_pkg::uvdc_state_t st_r;
  uvdc_pkg::uvdc_state_t st_nxt;
  logic                  below_sync;
  logic                  poc_sync;
  logic                  flag;
  logic                  other_rst;
  logic                  wr_ctrl;
  logic                  wr_level;
  logic                  rd_ctrl;
  logic                  rd_level;
  logic [7:0]            ctrl_rd;
  logic [7:0]            level_rd;
  logic [7:0]            cause_set;

  uvdc_sync #(.STAGES(uvdc_pkg::SYNC_STAGES)) u_cmp_sync (
    .mclk   (mclk),
    .arst_n (arst_n),
    .d      (cmp_below),
    .q      (below_sync)
  );

  uvdc_sync #(.STAGES(uvdc_pkg::SYNC_STAGES)) u_poc_sync (
    .mclk   (mclk),
    .arst_n (arst_n),
    .d      (poc_below),
    .q      (poc_sync)
  );

  // flag ignores comparator while off; no clock gating so it runs in stop mode
  assign flag      = st_r.on & below_sync;
  assign other_rst = wdog_rst | clkmon_rst | poc_rst;

  // address decode, one write and one read strobe per register
  assign wr_ctrl  = bus.wr & (bus.addr == uvdc_pkg::ADDR_CTRL);
  assign wr_level = bus.wr & (bus.addr == uvdc_pkg::ADDR_LEVEL);
  assign rd_ctrl  = bus.rd & (bus.addr == uvdc_pkg::ADDR_CTRL);
  assign rd_level = bus.rd & (bus.addr == uvdc_pkg::ADDR_LEVEL);

  // level register reads back its three code bits only
  always_comb begin
    level_rd      = 8'h00;
    level_rd[2:0] = st_r.level;
  end

  // one set request each for the undervoltage, watchdog and clock-monitor resets; power-on-clear has none
  always_comb begin
    cause_set                         = 8'h00;
    cause_set[uvdc_pkg::CAUSE_UV]     = st_r.uv_rst;
    cause_set[uvdc_pkg::CAUSE_WDOG]   = wdog_rst;
    cause_set[uvdc_pkg::CAUSE_CLKMON] = clkmon_rst;
  end

  always_comb begin
    ctrl_rd                     = 8'h00;
    ctrl_rd[uvdc_pkg::BIT_ON]   = st_r.on;
    ctrl_rd[uvdc_pkg::BIT_REF]  = st_r.ref_en;
    ctrl_rd[uvdc_pkg::BIT_ACT]  = st_r.act_rst;
    ctrl_rd[uvdc_pkg::BIT_FLAG] = flag;
  end

  always_comb begin
    st_nxt = st_r;
    // control write; flag and unused bits are not stored
    if (wr_ctrl) begin
      st_nxt.on      = bus.wdata[uvdc_pkg::BIT_ON];
      st_nxt.act_rst = bus.wdata[uvdc_pkg::BIT_ACT];
      // stored bit stays zero when the generator is forced on
      if (!POC_FITTED) begin
        st_nxt.ref_en = bus.wdata[uvdc_pkg::BIT_REF];
      end
    end
    // code 7 is kept as written, software must not use it
    if (wr_level) begin
      st_nxt.level = bus.wdata[2:0];
    end
    // other internal resets clear control bits, undervoltage reset does not
    if (other_rst) begin
      st_nxt.on      = 1'b0;
      st_nxt.ref_en  = 1'b0;
      st_nxt.act_rst = 1'b0;
      st_nxt.level   = uvdc_pkg::LEVEL_RESET[2:0];
    end
    // read data, unmapped reads return zero
    st_nxt.rdata = 8'h00;
    if (rd_ctrl) begin
      st_nxt.rdata = ctrl_rd;
    end else if (rd_level) begin
      st_nxt.rdata = level_rd;
    end
    // built from the new control bits so a request never outlives detector_on
    st_nxt.irq    = below_sync & st_nxt.on & ~st_nxt.act_rst;
    st_nxt.uv_rst = below_sync & st_nxt.on & st_nxt.act_rst;
    // a cause raised in the clearing cycle survives the clear
    if (poc_rst) begin
      st_nxt.cause = uvdc_pkg::CAUSE_RESET;
    end
    st_nxt.cause = st_nxt.cause | cause_set;
    // power-on-clear reset follows its synchronised comparator
    st_nxt.power_on_clear = POC_FITTED & poc_sync;
  end

  // only the external reset acts asynchronously; internal ones go through st_nxt
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_r     <= '0;
      st_r.power_on_clear <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata               = st_r.rdata;
  assign cmp_enable          = st_r.on;
  // generator forced on when fitted, while the register bit reads zero
  assign ref_enable          = st_r.ref_en | POC_FITTED;
  assign detect_level_select = st_r.level;
  assign undervoltage_irq    = st_r.irq;
  assign undervoltage_rst    = st_r.uv_rst;
  assign poc_rst             = st_r.power_on_clear;
  assign reset_cause_flags   = st_r.cause;
endmodule // uvdc_ctrl

// [uvdc_analog.sv]
// comparator and reference model facing uvdc_ctrl
// assumes supply given in millivolts by the bench
`timescale 1ns/1ps
module uvdc_analog #(parameter int POC_MV = 2850) (
  // supply
  input int           supply_mv,
  // controls
  input logic         cmp_enable,
  input logic         ref_enable,
  input logic [2:0]   detect_level_select,
  // results
  output logic        cmp_below,
  output logic        poc_below
);
  // output idles low when stopped, so the flag reads clear
  // no settling time modelled, so the software waits shrink to sync latency
  assign cmp_below = cmp_enable && ref_enable && supply_mv < 4300 - 200 * detect_level_select;
  assign poc_below = supply_mv < POC_MV;
endmodule // uvdc_analog

// [uvdc_monitor.sv]
// assertions on the uvdc_ctrl ports
// assumes one mclk domain, bound below
`timescale 1ns/1ps
module uvdc_monitor #(parameter bit POC_FITTED = 1'b1) (
  // clock and reset
  input wire logic                mclk,
  input wire logic                arst_n,
  // register port
  input wire uvdc_pkg::uvdc_bus_t bus,
  input wire logic [7:0]          rdata,
  // analog side
  input wire logic                cmp_below,
  input wire logic                poc_below,
  input wire logic                cmp_enable,
  input wire logic                ref_enable,
  // resets and outputs
  input wire logic                wdog_rst,
  input wire logic                clkmon_rst,
  input wire logic                undervoltage_irq,
  input wire logic                undervoltage_rst,
  input wire logic                poc_rst,
  input wire logic [7:0]          reset_cause_flags
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence s_uv; undervoltage_rst && !poc_rst; endsequence
  property p_on; bus.wr && bus.addr == uvdc_pkg::ADDR_CTRL && !wdog_rst && !clkmon_rst && !poc_rst
    |=> cmp_enable == $past(bus.wdata[7]); endproperty
  a_on: assert property (p_on) else $error("on bit");
  property p_irq; undervoltage_irq |-> cmp_enable && !undervoltage_rst; endproperty
  a_irq: assert property (p_irq) else $error("irq gate");
  property p_uv; s_uv |-> ##[1:2] reset_cause_flags[0]; endproperty
  a_uv: assert property (p_uv) else $error("uv cause");
  property p_poc; poc_rst && !(wdog_rst || clkmon_rst || undervoltage_rst)
    |=> reset_cause_flags == 8'h00; endproperty
  a_poc: assert property (p_poc) else $error("poc clear");
  property p_wd; wdog_rst && !poc_rst |=> !cmp_enable ##[0:1] reset_cause_flags[4]; endproperty
  a_wd: assert property (p_wd) else $error("wdog reset");
  property p_keep; $fell(reset_cause_flags[0]) |-> $past(poc_rst); endproperty
  a_keep: assert property (p_keep) else $error("cause lost");
  property p_rd; $past(bus.rd) && $past(bus.addr) == uvdc_pkg::ADDR_CTRL
    |-> rdata[6:5] == 2'h0 && rdata[3:2] == 2'h0 && (!rdata[0] || rdata[7]); endproperty
  a_rd: assert property (p_rd) else $error("ctrl read");
  property p_ref; ref_enable == POC_FITTED; endproperty
  a_ref: assert property (p_ref) else $error("ref on");
  property p_sync; $rose(cmp_below) && !undervoltage_irq |=> !undervoltage_irq [*2]; endproperty
  a_sync: assert property (p_sync) else $error("no sync");
  property p_pr; poc_below [*4] |-> poc_rst; endproperty
  a_pr: assert property (p_pr) else $error("poc reset");
endmodule // uvdc_monitor
bind uvdc_ctrl uvdc_monitor #(.POC_FITTED(POC_FITTED)) u_mon (.*);

// [test_uvdc_ctrl.sv]
// self-checking bench for uvdc_ctrl
// assumes power-on-clear fitted, so the reference always runs
`timescale 1ns/1ps
module test_uvdc_ctrl;
  logic mclk = 0, arst_n = 0, wdog_rst = 0, clkmon_rst = 0;
  uvdc_pkg::uvdc_bus_t bus = '0;
  int supply_mv = 5000, n_mismatch = 0, total_checks = 0, cyc = 0;
  logic [7:0] rdata, reset_cause_flags;
  logic [2:0] detect_level_select;
  logic cmp_below, poc_below, cmp_enable, ref_enable, undervoltage_irq, undervoltage_rst, poc_rst;
  always #5 mclk = ~mclk;
  uvdc_ctrl i_dut (.mclk, .arst_n, .bus, .rdata, .cmp_below, .poc_below, .cmp_enable, .ref_enable,
    .detect_level_select, .wdog_rst, .clkmon_rst, .undervoltage_irq, .undervoltage_rst, .poc_rst,
    .reset_cause_flags);
  uvdc_analog i_ana (.supply_mv, .cmp_enable, .ref_enable, .detect_level_select, .cmp_below, .poc_below);
  task chk(input bit ok, input string s);
    total_checks++;
    if (!ok) begin
      n_mismatch++;
      $display("mismatch %0t %s", $time, s);
    end
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d);
    bus.wr = 1; bus.addr = a; bus.wdata = d;
    @(posedge mclk); #1 bus.wr = 0;
    // idle edge so a following write never re-raises the strobe in this step
    @(posedge mclk); #1;
  endtask
  task rd(input logic [15:0] a, input logic [7:0] m, e, input string s);
    bus.rd = 1; bus.addr = a;
    @(posedge mclk); #1 bus.rd = 0;
    chk((rdata & m) === e, s);
  endtask
  // comparator path needs sync plus register, six edges covers it
  task settle(input int mv);
    supply_mv = mv;
    repeat (6) @(posedge mclk);
    #1;
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task t_regs;
    rd(uvdc_pkg::ADDR_CTRL, 8'hff, 8'h00, "ctrl reset");
    wr(uvdc_pkg::ADDR_LEVEL, 8'h06);
    chk(detect_level_select === 3'h6, "level out");
    rd(uvdc_pkg::ADDR_LEVEL, 8'hff, 8'h06, "level bits");
    wr(uvdc_pkg::ADDR_CTRL, 8'hff);
    chk(cmp_enable === 1'b1 && ref_enable === 1'b1, "enables");
    rd(uvdc_pkg::ADDR_CTRL, 8'h7d, 8'h00, "unused bits");
    $display("done t_regs");
  endtask
  task t_irq;
    wr(uvdc_pkg::ADDR_LEVEL, 8'h02);
    wr(uvdc_pkg::ADDR_CTRL, 8'h80);
    settle(3800);
    chk(undervoltage_irq === 1'b1 && undervoltage_rst === 1'b0, "irq");
    rd(uvdc_pkg::ADDR_CTRL, 8'hef, 8'h81, "flag set");
    wr(uvdc_pkg::ADDR_CTRL, 8'h00);
    settle(3800);
    rd(uvdc_pkg::ADDR_CTRL, 8'hff, 8'h00, "flag off");
    chk(undervoltage_irq === 1'b0, "irq off");
    $display("done t_irq");
  endtask
  task t_uv;
    wr(uvdc_pkg::ADDR_CTRL, 8'h82);
    settle(3800);
    chk(undervoltage_rst === 1'b1 && undervoltage_irq === 1'b0, "uv reset");
    chk(reset_cause_flags === 8'h01, "uv cause");
    rd(uvdc_pkg::ADDR_CTRL, 8'hef, 8'h83, "ctrl kept");
    settle(5000);
    chk(undervoltage_rst === 1'b0, "uv release");
    $display("done t_uv");
  endtask
  task t_rst;
    wdog_rst = 1; @(posedge mclk); #1 wdog_rst = 0;
    clkmon_rst = 1; @(posedge mclk); #1 clkmon_rst = 0;
    @(posedge mclk); #1;
    chk(reset_cause_flags === 8'h13, "causes");
    rd(uvdc_pkg::ADDR_CTRL, 8'hef, 8'h00, "ctrl cleared");
    settle(2500);
    chk(poc_rst === 1'b1 && reset_cause_flags === 8'h00, "poc");
    settle(5000);
    chk(poc_rst === 1'b0, "poc release");
    $display("done t_rst");
  endtask
  task t_ext;
    wr(uvdc_pkg::ADDR_CTRL, 8'h82);
    arst_n = 0;
    #1 chk(poc_rst === 1'b1 && cmp_enable === 1'b0, "ext reset hold");
    repeat (2) @(posedge mclk);
    #1 arst_n = 1;
    @(posedge mclk); #1;
    rd(uvdc_pkg::ADDR_CTRL, 8'hff, 8'h00, "ext reset ctrl");
    chk(poc_rst === 1'b0 && undervoltage_rst === 1'b0, "ext reset release");
    $display("done t_ext");
  endtask
  always @(posedge mclk) if (++cyc == 3000) begin
    n_mismatch++;
    close_out();
  end
  initial begin
    repeat (2) @(posedge mclk);
    #1 arst_n = 1;
    @(posedge mclk); #1;
    t_regs();
    t_irq();
    t_uv();
    t_rst();
    t_ext();
    close_out();
  end
endmodule // test_uvdc_ctrl
